// ==== shared/wake_defines.svh ====
// Register indices, field positions, reset values and timing figures.
// Assumes inclusion by bare name from the design file.
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH
// ********************
// Register indices (byte address is four times the index)
// ********************
`define IDX_WAKE_CTL   8'hE0
`define IDX_PW_INDEX   8'hE1
`define IDX_PW_DATA    8'hE2
`define IDX_LOSS_POL   8'hE4
`define IDX_PG_MOUSE   8'hE6
`define IDX_STATUS     8'hE8
// ********************
// Field positions
// ********************
`define B_KBD_EN       6
`define B_MOUSE_EN     5
`define B_BTN_SEL      4
`define B_CLICK_SEL    1
`define B_ANY_KEY      0
`define B_POL_HI       6
`define B_POL_LO       5
`define B_BROAD        7
`define B_USER_OFF     4
`define B_FIRST_SHORT  3
`define B_SECOND_HI    2
`define B_SECOND_LO    1
// ********************
// Reset values
// ********************
`define RST_WAKE_CTL   8'h01
`define RST_ZERO       8'h00
// ********************
// Password storage
// ********************
`define PW_BASE0       7'h00
`define PW_BASE1       7'h30
`define PW_BASE2       7'h40
`define PW_SET_LEN     15
`define PW_DEPTH       80
// ********************
// Timing, in ms, and clock rate in kHz
// ********************
`define CLK_KHZ        125000
`define SB_DLY_MS      150
`define PG_FIRST_MS    400
`define PG_SHORT_MS    250
`define PG_EXT1_MS     32
`define PG_EXT2_MS     96
`define PG_EXT3_MS     250
`define WAKE_PULSE_MS  16
`endif

// ==== shared/wake_pkg.sv ====
// Types shared by the sequencer.
// Assumes nothing of its surroundings.
package wake_pkg;
  typedef enum logic [1:0] {POL_OFF, POL_ON, POL_LAST, POL_USER} policy_type;
  typedef enum logic [1:0] {PG_LOW, PG_FIRST, PG_SECOND, PG_ON} pg_state_type;
endpackage : wake_pkg

// ==== hw/power_resume_wake_sequencer.sv ====
// Standby-domain power sequencer: resume policy, wake pulses, supply resets.
// Assumes keyboard bytes and mouse events come from logic on ref_clk;
// supply comparators, sleep state and button arrive asynchronously.
//
// Contract
// - Two-bit policy picks state after standby returns.
// - Last state comes from sleep input and 5V.
// - User bit: 0 turns on, 1 stays off.
// - Qualified key or click pulses button output low.
// - Keyboard wakes only when bit 6 set.
// - Bit 0 picks any key or password.
// - Three password sets behind index/data registers.
// - Mouse wakes only when bit 5 set.
// - Broad mode: any activity or one click.
// - Narrow mode: button and click count select.
// - Standby reset rises after delay once valid.
// - Standby reset falls at once on loss.
// - Power good rises after first-stage delay.
// - Power good falls at once on loss.
// - Bit 3 shortens the first-stage delay.
// - Bits 2:1 add a second-stage delay.
// - Total delay is first stage plus second.
// - Button output follows a low button input.
`include "wake_defines.svh"
module power_resume_wake_sequencer #(
  parameter int SB_DLY_CYC  = `SB_DLY_MS * `CLK_KHZ,
  parameter int PG_FIRST_CYC = `PG_FIRST_MS * `CLK_KHZ,
  parameter int PG_SHORT_CYC = `PG_SHORT_MS * `CLK_KHZ,
  parameter int PG_EXT1_CYC = `PG_EXT1_MS * `CLK_KHZ,
  parameter int PG_EXT2_CYC = `PG_EXT2_MS * `CLK_KHZ,
  parameter int PG_EXT3_CYC = `PG_EXT3_MS * `CLK_KHZ,
  parameter int WAKE_CYC    = `WAKE_PULSE_MS * `CLK_KHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        standby_5v_supply,
  input  wire logic        main_5v_supply,
  input  wire logic        main_3v3_supply,
  input  wire logic        sleep_s3_in_n,
  input  wire logic        power_button_in_n,
  input  wire logic [7:0]  kbd_byte,
  input  wire logic        kbd_byte_valid,
  input  wire logic        mouse_left_click,
  input  wire logic        mouse_right_click,
  input  wire logic        mouse_move,
  output logic             power_button_out_n,
  output logic             standby_reset_out_n,
  output logic             main_power_good
);
  localparam int CW = 27;

  // ************************************************************
  // Reset release and input synchronisers
  // ************************************************************
  logic [1:0] rst_sync_r;
  logic       rst_l;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_l = rst_sync_r[1];

  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      pin_s1_r <= 5'h18;
      pin_s2_r <= 5'h18;
    end
    else
    begin
      pin_s1_r <= {power_button_in_n, sleep_s3_in_n, main_3v3_supply, main_5v_supply, standby_5v_supply};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic sb_ok, m5_ok, main_ok, slp_n, btn_n;
  assign sb_ok   = pin_s2_r[0];
  assign m5_ok   = pin_s2_r[1];
  assign main_ok = pin_s2_r[1] & pin_s2_r[2];
  assign slp_n   = pin_s2_r[3];
  assign btn_n   = pin_s2_r[4];

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] wake_ctl_r, pw_index_r, loss_pol_r, pg_mouse_r;
  logic [7:0] pw_mem [0:`PW_DEPTH-1];
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_full_r, w_full_r;
  logic        do_wr;
  logic [7:0]  wr_idx;

  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
             (i == `IDX_WAKE_CTL || i == `IDX_PW_INDEX || i == `IDX_PW_DATA ||
              i == `IDX_LOSS_POL || i == `IDX_PG_MOUSE || i == `IDX_STATUS);
  endfunction : mapped

  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready  = !w_full_r;
  assign do_wr  = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_idx = aw_addr_r[9:2];

  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_r)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      wake_ctl_r <= `RST_WAKE_CTL;
      pw_index_r <= `RST_ZERO;
      loss_pol_r <= `RST_ZERO;
      pg_mouse_r <= `RST_ZERO;
    end
    else if (do_wr && w_strb_r[0] && mapped(aw_addr_r))
    begin
      if (wr_idx == `IDX_WAKE_CTL)
        wake_ctl_r <= w_data_r[7:0];
      if (wr_idx == `IDX_PW_INDEX)
        pw_index_r <= w_data_r[7:0];
      if (wr_idx == `IDX_LOSS_POL)
        loss_pol_r <= w_data_r[7:0];
      if (wr_idx == `IDX_PG_MOUSE)
        pg_mouse_r <= w_data_r[7:0];
    end
  end

  // Storage has no reset; software loads every byte it relies on.
  always_ff @(posedge ref_clk)
  begin
    if (do_wr && w_strb_r[0] && mapped(aw_addr_r) && wr_idx == `IDX_PW_DATA && pw_index_r < 8'(`PW_DEPTH))
      pw_mem[pw_index_r[6:0]] <= w_data_r[7:0];
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic [7:0] status;
  logic       wake_busy;
  logic       last_on_r;
  assign s_axi_arready = !s_axi_rvalid;

  function automatic logic [7:0] rd_reg(input logic [7:0] i, input logic [7:0] pw, input logic [7:0] st);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      `IDX_WAKE_CTL: v = wake_ctl_r;
      `IDX_PW_INDEX: v = pw_index_r;
      `IDX_PW_DATA:  v = pw;
      `IDX_LOSS_POL: v = loss_pol_r;
      `IDX_PG_MOUSE: v = pg_mouse_r;
      `IDX_STATUS:   v = st;
      default:       v = 8'h00;
    endcase
    rd_reg = v;
  endfunction : rd_reg

  assign status = {4'h0, wake_busy, last_on_r, main_power_good, standby_reset_out_n};

  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      s_axi_rdata  <= mapped(s_axi_araddr) ?
                      {24'h00_0000, rd_reg(s_axi_araddr[9:2],
                       (pw_index_r < 8'(`PW_DEPTH)) ? pw_mem[pw_index_r[6:0]] : 8'h00, status)} : 32'h0000_0000;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ************************************************************
  // Standby reset and power good
  // ************************************************************
  logic [CW-1:0] sb_cnt_r, pg_cnt_r, first_cyc, second_cyc;
  wake_pkg::pg_state_type pg_state_r;

  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      sb_cnt_r <= '0;
      standby_reset_out_n <= 1'b0;
    end
    else if (!sb_ok)
    begin
      sb_cnt_r <= '0;
      standby_reset_out_n <= 1'b0;
    end
    else if (sb_cnt_r >= CW'(SB_DLY_CYC))
      standby_reset_out_n <= 1'b1;
    else
      sb_cnt_r <= sb_cnt_r + 1'b1;
  end

  always_comb
  begin
    first_cyc = pg_mouse_r[`B_FIRST_SHORT] ? CW'(PG_SHORT_CYC) : CW'(PG_FIRST_CYC);
    unique case ({pg_mouse_r[`B_SECOND_HI], pg_mouse_r[`B_SECOND_LO]})
      2'h0: second_cyc = '0;
      2'h1: second_cyc = CW'(PG_EXT1_CYC);
      2'h2: second_cyc = CW'(PG_EXT2_CYC);
      2'h3: second_cyc = CW'(PG_EXT3_CYC);
    endcase
  end

  // The first stage ends before the second starts; both use pg_cnt_r, cleared between them.
  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      pg_state_r <= wake_pkg::PG_LOW;
      pg_cnt_r   <= '0;
      main_power_good <= 1'b0;
    end
    else if (!main_ok)
    begin
      pg_state_r <= wake_pkg::PG_LOW;
      pg_cnt_r   <= '0;
      main_power_good <= 1'b0;
    end
    else
      unique case (pg_state_r)
        wake_pkg::PG_LOW:
          pg_state_r <= wake_pkg::PG_FIRST;
        wake_pkg::PG_FIRST:
          if (pg_cnt_r >= first_cyc)
          begin
            pg_cnt_r   <= '0;
            pg_state_r <= wake_pkg::PG_SECOND;
          end
          else
            pg_cnt_r <= pg_cnt_r + 1'b1;
        wake_pkg::PG_SECOND:
          if (pg_cnt_r >= second_cyc)
          begin
            pg_state_r <= wake_pkg::PG_ON;
            main_power_good <= 1'b1;
          end
          else
            pg_cnt_r <= pg_cnt_r + 1'b1;
        wake_pkg::PG_ON:
          main_power_good <= 1'b1;
      endcase
  end

  // ************************************************************
  // Resume policy
  // ************************************************************
  logic m5_d_r, sbr_d_r, resume_on;
  wake_pkg::policy_type pol;
  assign pol = wake_pkg::policy_type'(loss_pol_r[`B_POL_HI:`B_POL_LO]);

  // A main 5 V supply that falls while the sleep input is high means the system was on.
  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      m5_d_r    <= 1'b0;
      sbr_d_r   <= 1'b0;
      last_on_r <= 1'b0;
    end
    else
    begin
      m5_d_r  <= m5_ok;
      sbr_d_r <= standby_reset_out_n;
      if (m5_d_r && !m5_ok)
        last_on_r <= slp_n;
    end
  end

  always_comb
  begin
    unique case (pol)
      wake_pkg::POL_OFF:  resume_on = 1'b0;
      wake_pkg::POL_ON:   resume_on = 1'b1;
      wake_pkg::POL_LAST: resume_on = last_on_r;
      wake_pkg::POL_USER: resume_on = !pg_mouse_r[`B_USER_OFF];
    endcase
  end

  logic resume_req;
  assign resume_req = standby_reset_out_n && !sbr_d_r && resume_on;

  // ************************************************************
  // Keyboard wake
  // ************************************************************
  logic [3:0] ptr_r [0:2];
  logic [3:0] ptr_nxt [0:2];
  logic       pw_hit;
  logic       kbd_wake;
  logic       pw_mode;
  assign pw_mode = wake_ctl_r[`B_KBD_EN] && !wake_ctl_r[`B_ANY_KEY];

  function automatic logic [6:0] set_base(input int s);
    set_base = (s == 0) ? `PW_BASE0 : (s == 1) ? `PW_BASE1 : `PW_BASE2;
  endfunction : set_base

  // A mismatch restarts the set, counting the byte as a first key if it fits.
  always_comb
  begin
    logic [7:0] cur;
    cur = 8'h00;
    pw_hit = 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      ptr_nxt[s] = ptr_r[s];
      cur = pw_mem[set_base(s) + 7'(ptr_r[s])];
      if (kbd_byte_valid && pw_mode)
      begin
        if (kbd_byte == cur && cur != 8'h00)
        begin
          if (ptr_r[s] == 4'(`PW_SET_LEN - 1) || pw_mem[set_base(s) + 7'(ptr_r[s]) + 7'h01] == 8'h00)
          begin
            pw_hit = 1'b1;
            ptr_nxt[s] = 4'h0;
          end
          else
            ptr_nxt[s] = ptr_r[s] + 4'h1;
        end
        else
          ptr_nxt[s] = (kbd_byte == pw_mem[set_base(s)] && kbd_byte != 8'h00) ? 4'h1 : 4'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      for (int s = 0; s < 3; s++)
        ptr_r[s] <= 4'h0;
    else
      for (int s = 0; s < 3; s++)
        ptr_r[s] <= pw_hit ? 4'h0 : ptr_nxt[s];
  end

  assign kbd_wake = wake_ctl_r[`B_KBD_EN] && kbd_byte_valid &&
                    (wake_ctl_r[`B_ANY_KEY] || pw_hit);

  // ************************************************************
  // Mouse wake
  // ************************************************************
  logic mouse_wake, sel_click, clicks_r;
  assign sel_click = wake_ctl_r[`B_BTN_SEL] ? mouse_right_click : mouse_left_click;

  always_comb
  begin
    mouse_wake = 1'b0;
    if (wake_ctl_r[`B_MOUSE_EN])
    begin
      if (pg_mouse_r[`B_BROAD])
        mouse_wake = wake_ctl_r[`B_CLICK_SEL] ?
                     (mouse_left_click | mouse_right_click | mouse_move) :
                     (mouse_left_click | mouse_right_click);
      else
        mouse_wake = sel_click && (wake_ctl_r[`B_CLICK_SEL] || clicks_r);
    end
  end

  // There is no window between the two clicks of a double click.
  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      clicks_r <= 1'b0;
    else if (!wake_ctl_r[`B_MOUSE_EN] || mouse_wake)
      clicks_r <= 1'b0;
    else if (sel_click)
      clicks_r <= 1'b1;
  end

  // ************************************************************
  // Power button output
  // ************************************************************
  logic [CW-1:0] pulse_cnt_r;
  assign wake_busy = pulse_cnt_r != '0;

  // New wake events during a pulse are absorbed by it.
  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      pulse_cnt_r <= '0;
    else if (!wake_busy && (kbd_wake || mouse_wake || resume_req))
      pulse_cnt_r <= CW'(WAKE_CYC);
    else if (wake_busy)
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      power_button_out_n <= 1'b1;
    else
      power_button_out_n <= btn_n && !wake_busy;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [CW-1:0] sb_run_r, ok_run_r;
  always_ff @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      sb_run_r <= '0;
      ok_run_r <= '0;
    end
    else
    begin
      sb_run_r <= sb_ok ? sb_run_r + 1'b1 : '0;
      ok_run_r <= main_ok ? ok_run_r + 1'b1 : '0;
    end
  end

  property p_sb_drop;
    @(posedge ref_clk) disable iff (!rst_l) !sb_ok |=> !standby_reset_out_n;
  endproperty
  a_sb_drop: assert property (p_sb_drop) else $error("Standby reset late on loss.");

  property p_sb_rise;
    @(posedge ref_clk) disable iff (!rst_l) $rose(standby_reset_out_n) |-> sb_run_r > CW'(SB_DLY_CYC);
  endproperty
  a_sb_rise: assert property (p_sb_rise) else $error("Standby reset rose early.");

  property p_pg_drop;
    @(posedge ref_clk) disable iff (!rst_l) !main_ok |=> !main_power_good;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("Power good late on loss.");

  property p_pg_rise;
    @(posedge ref_clk) disable iff (!rst_l) $rose(main_power_good) |-> ok_run_r > first_cyc + second_cyc;
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("Power good rose early.");

  property p_btn_follow;
    @(posedge ref_clk) disable iff (!rst_l) !btn_n |=> !power_button_out_n;
  endproperty
  a_btn_follow: assert property (p_btn_follow) else $error("Button input not passed.");

  property p_kbd_off;
    @(posedge ref_clk) disable iff (!rst_l) !wake_ctl_r[`B_KBD_EN] |-> !kbd_wake;
  endproperty
  a_kbd_off: assert property (p_kbd_off) else $error("Keyboard wake while disabled.");

  property p_mouse_off;
    @(posedge ref_clk) disable iff (!rst_l) !wake_ctl_r[`B_MOUSE_EN] |-> !mouse_wake;
  endproperty
  a_mouse_off: assert property (p_mouse_off) else $error("Mouse wake while disabled.");

  property p_pulse;
    @(posedge ref_clk) disable iff (!rst_l) $rose(wake_busy) |=> !power_button_out_n [*4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("Wake pulse too short.");

  property p_policy_off;
    @(posedge ref_clk) disable iff (!rst_l) pol == wake_pkg::POL_OFF |-> !resume_req;
  endproperty
  a_policy_off: assert property (p_policy_off) else $error("Resume with off policy.");
endmodule : power_resume_wake_sequencer

// ==== verif/far_model.sv ====
// Far-side model: supply comparators, chipset sleep, button, keyboard, mouse.
// Assumes the bench calls its tasks; pins change just after a rising edge.
module far_model (
  input  wire logic ref_clk,
  output logic      standby_5v_supply,
  output logic      main_5v_supply,
  output logic      main_3v3_supply,
  output logic      sleep_s3_in_n,
  output logic      power_button_in_n,
  output logic [7:0] kbd_byte,
  output logic      kbd_byte_valid,
  output logic      mouse_left_click,
  output logic      mouse_right_click,
  output logic      mouse_move
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Pin drivers
  // ********************
  initial
  begin
    {standby_5v_supply, main_5v_supply, main_3v3_supply} = 3'h0;
    sleep_s3_in_n = 1'b0;
    power_button_in_n = 1'b1;
    kbd_byte = 8'h00;
    kbd_byte_valid = 1'b0;
    {mouse_left_click, mouse_right_click, mouse_move} = 3'h0;
  end
  // Order is standby, main 5 V, main 3.3 V, sleep, button; supplies are comparator levels.
  task automatic pins(input logic [4:0] p);
    @(posedge ref_clk);
    {standby_5v_supply, main_5v_supply, main_3v3_supply, sleep_s3_in_n, power_button_in_n} <= p;
  endtask : pins
  task automatic key(input logic [7:0] b);
    @(posedge ref_clk);
    kbd_byte <= b;
    kbd_byte_valid <= 1'b1;
    @(posedge ref_clk);
    kbd_byte_valid <= 1'b0;
    // The stale byte is inverted so nothing can lean on a held value.
    kbd_byte <= ~b;
  endtask : key
  task automatic mouse(input int k);
    @(posedge ref_clk);
    {mouse_left_click, mouse_right_click, mouse_move} <= {k == 0, k == 1, k == 2};
    @(posedge ref_clk);
    {mouse_left_click, mouse_right_click, mouse_move} <= 3'h0;
  endtask : mouse
endmodule : far_model

// ==== verif/tb_power_resume_wake_sequencer.sv ====
// Bench for the sequencer: AXI4-Lite master, far-side model, checks.
// Assumes shortened delay parameters so the run stays short.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_power_resume_wake_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WK = 8;
  localparam logic [7:0] POL [6] = '{8'h20, 8'h00, 8'h60, 8'h60, 8'h40, 8'h40};
  localparam logic [7:0] USR [6] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
  localparam int ON [6] = '{1, 0, 0, 1, 0, 1};
  localparam logic [7:0] PGC [4] = '{8'h00, 8'h0A, 8'h0C, 8'h0E};
  localparam int PGX [4] = '{40, 35, 40, 45};
  localparam logic [7:0] WE0 [10] = '{8'h20, 8'h20, 8'h32, 8'h32, 8'h22, 8'h20, 8'h20, 8'h02, 8'h01, 8'h41};
  localparam logic [7:0] WE6 [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
  localparam int WEV [10] = '{0, 0, 0, 1, 2, 2, 1, 2, 3, 3};
  localparam int WON [10] = '{0, 1, 0, 1, 1, 0, 1, 0, 0, 1};
  localparam logic [7:0] PWB [3] = '{8'h00, 8'h30, 8'h40};
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, kbd_byte_valid, mouse_left_click;
  logic standby_5v_supply, main_5v_supply, main_3v3_supply, sleep_s3_in_n, power_button_in_n;
  logic mouse_right_click, mouse_move, power_button_out_n, standby_reset_out_n, main_power_good;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] kbd_byte;
  int err_total, cmp_count, cyc, n;
  power_resume_wake_sequencer #(.SB_DLY_CYC(20), .PG_FIRST_CYC(40), .PG_SHORT_CYC(30), .PG_EXT1_CYC(5),
    .PG_EXT2_CYC(10), .PG_EXT3_CYC(15), .WAKE_CYC(WK)) power_resume_wake_sequencer_inst (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .standby_5v_supply, .main_5v_supply, .main_3v3_supply, .sleep_s3_in_n, .power_button_in_n,
    .kbd_byte, .kbd_byte_valid, .mouse_left_click, .mouse_right_click, .mouse_move,
    .power_button_out_n, .standby_reset_out_n, .main_power_good);
  far_model far_model_inst (.ref_clk, .standby_5v_supply, .main_5v_supply, .main_3v3_supply,
    .sleep_s3_in_n, .power_button_in_n, .kbd_byte, .kbd_byte_valid, .mouse_left_click,
    .mouse_right_click, .mouse_move);
  // ********************
  // Bus and measurement tasks
  // ********************
  // Handshakes are judged on the values that stand at the rising edge itself.
  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] idx);
    @(posedge ref_clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // Waits for a wake pulse, if any, and checks its width.
  task automatic pulse(input int want);
    int s, w;
    s = 0;
    w = 0;
    while (power_button_out_n !== 1'b0 && s < 40)
    begin
      @(negedge ref_clk);
      s++;
    end
    while (power_button_out_n === 1'b0 && w < 100)
    begin
      @(negedge ref_clk);
      w++;
    end
    `CHK("wake_pulse_width", want * WK, w)
  endtask : pulse
  task automatic wait_hi(input int pg);
    n = 0;
    while ((pg ? main_power_good : standby_reset_out_n) !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_hi
  // ********************
  // Scenarios
  // ********************
  task automatic t_regs;
    axr(8'hE0);
    `CHK("wake_ctl_reset", 8'h01, rd[7:0])
    axr(8'hE4);
    `CHK("policy_reset", 8'h00, rd[7:0])
    axr(8'hFF);
    `CHK("unmapped_resp", 2'b10, rsp)
    s_axi_wstrb <= 4'h0;
    axw(8'hE4, 8'h60);
    `CHK("strobe_off_bresp", 2'b00, rsp)
    s_axi_wstrb <= 4'hF;
    axr(8'hE4);
    `CHK("strobe_off_write", 8'h00, rd[7:0])
  endtask : t_regs
  task automatic t_resume;
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5)
      begin
        far_model_inst.pins(5'b11011);
        repeat (6) @(posedge ref_clk);
        far_model_inst.pins(5'b10011);
        repeat (6) @(posedge ref_clk);
      end
      axw(8'hE4, POL[i]);
      axw(8'hE6, USR[i]);
      far_model_inst.pins(5'b00001);
      repeat (5) @(negedge ref_clk);
      `CHK("standby_reset_fall", 1'b0, standby_reset_out_n)
      far_model_inst.pins(5'b10001);
      wait_hi(0);
      `CHK("standby_reset_delay", 1'b1, n >= 20 && n <= 26)
      pulse(ON[i]);
    end
  endtask : t_resume
  task automatic t_power_good;
    for (int i = 0; i < 4; i++)
    begin
      axw(8'hE6, PGC[i]);
      far_model_inst.pins((i % 2) ? 5'b11011 : 5'b10111);
      repeat (5) @(negedge ref_clk);
      `CHK("power_good_fall", 1'b0, main_power_good)
      far_model_inst.pins(5'b11111);
      wait_hi(1);
      `CHK("power_good_delay", 1'b1, n >= PGX[i] && n <= PGX[i] + 6)
    end
  endtask : t_power_good
  task automatic t_button;
    far_model_inst.pins(5'b11110);
    repeat (14) @(negedge ref_clk);
    `CHK("button_follow", 1'b0, power_button_out_n)
    far_model_inst.pins(5'b11111);
    repeat (6) @(negedge ref_clk);
    `CHK("button_release", 1'b1, power_button_out_n)
  endtask : t_button
  task automatic t_wake;
    for (int i = 0; i < 10; i++)
    begin
      axw(8'hE0, WE0[i]);
      axw(8'hE6, WE6[i]);
      if (WEV[i] == 3) far_model_inst.key(8'h1C);
      else far_model_inst.mouse(WEV[i]);
      pulse(WON[i]);
    end
  endtask : t_wake
  task automatic t_password;
    for (int s = 0; s < 3; s++)
      for (int j = 0; j < 15; j++)
      begin
        axw(8'hE1, PWB[s] + 8'(j));
        axw(8'hE2, (j == 1) ? 8'hF0 : (j < 3) ? 8'h45 : 8'h00);
      end
    axw(8'hE1, 8'h31);
    axr(8'hE2);
    `CHK("password_byte", 8'hF0, rd[7:0])
    axw(8'hE0, 8'h40);
    far_model_inst.key(8'h16);
    far_model_inst.key(8'hF0);
    far_model_inst.key(8'h16);
    pulse(0);
    far_model_inst.key(8'h45);
    far_model_inst.key(8'hF0);
    far_model_inst.key(8'h45);
    pulse(1);
  endtask : t_password
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Ceiling sits well above the few thousand cycles the scenarios need.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    {err_total, cmp_count, cyc} = '0;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_resume();
    t_power_good();
    t_button();
    t_wake();
    t_password();
    tally_and_finish();
  end
endmodule : tb_power_resume_wake_sequencer
